// ### src/saw_regs.vh
/*
  register map, field positions, reset values and timing counts of the
  sram area wait timing block.
  assumes inclusion by bare name from the design files of this block.
*/
`ifndef SAW_REGS_VH
`define SAW_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SAW_CTRL_OFFSET   12'h000
`define SAW_STAT_OFFSET   12'h004

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define SAW_WW_MSB        18
`define SAW_WW_LSB        16
`define SAW_AW_MSB        10
`define SAW_AW_LSB        7
`define SAW_WM_BIT        6
`define SAW_HW_MSB        1
`define SAW_HW_LSB        0
`define SAW_CTRL_RESET    32'h0000_0540
`define SAW_CTRL_WMASK    32'h0007_07c3

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define SAW_STAT_BUSY     0
`define SAW_STAT_STALL    1

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define SAW_WAIT_W        5
`define SAW_WAIT_MAX      5'h18

`endif

// ### src/saw_wait_decode.v
/*
  decodes the access wait and write wait codes into a wait cycle count.
  assumes the codes come straight from the control register.
*/
`timescale 1ns/1ps
`default_nettype none
`include "saw_regs.vh"

module saw_wait_decode (
  input  wire [3:0]                 access_wait,
  input  wire [2:0]                 write_wait_override,
  input  wire                       is_write,
  output reg  [`SAW_WAIT_W-1:0]     wait_cycles
);

  // ----------------------------------------------------------------------
  // code lookup
  // ----------------------------------------------------------------------
  always @* begin
    wait_cycles = `SAW_WAIT_MAX;
    if (is_write && (write_wait_override != 3'h0)) begin
      wait_cycles = {2'h0, write_wait_override} - 5'h01;
    end else begin
      case (access_wait)
        4'h0: wait_cycles = 5'h00;
        4'h1: wait_cycles = 5'h01;
        4'h2: wait_cycles = 5'h02;
        4'h3: wait_cycles = 5'h03;
        4'h4: wait_cycles = 5'h04;
        4'h5: wait_cycles = 5'h05;
        4'h6: wait_cycles = 5'h06;
        4'h7: wait_cycles = 5'h08;
        4'h8: wait_cycles = 5'h0a;
        4'h9: wait_cycles = 5'h0c;
        4'ha: wait_cycles = 5'h0e;
        4'hb: wait_cycles = 5'h12;
        // prohibited codes fall back to the longest wait, the safe side
        default: wait_cycles = `SAW_WAIT_MAX;
      endcase
    end
  end

endmodule // saw_wait_decode
`default_nettype wire

// ### src/saw_ctrl.v
/*
  sram area access timing controller with apb control registers.
  assumes an apb master on the same clock, a user request port held
  until taken, and a memory whose wait input is synchronous to clock.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "saw_regs.vh"

module saw_ctrl #(
  parameter ADDR_W = 16,
  parameter DATA_W = 16
) (
  input  wire                clock,
  input  wire                rstn,
  input  wire                ce,
  // apb slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output wire                pready,
  output reg  [31:0]         prdata,
  output wire                pslverr,
  // user request port
  input  wire                req_valid,
  input  wire                req_write,
  input  wire [ADDR_W-1:0]   req_addr,
  input  wire [DATA_W-1:0]   req_wdata,
  output wire                req_ready,
  output wire                req_done,
  output wire [DATA_W-1:0]   req_rdata,
  // memory pins
  output wire                chip_select_n,
  output wire [ADDR_W-1:0]   mem_addr,
  output wire                rd_n,
  output wire                we_n,
  output wire [DATA_W-1:0]   mem_data_out,
  output wire                mem_data_oe_n,
  input  wire [DATA_W-1:0]   mem_data_in,
  input  wire                ext_wait_n
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam ST_IDLE   = 2'h0;
  localparam ST_SETUP  = 2'h1;
  localparam ST_STROBE = 2'h2;
  localparam ST_HOLD   = 2'h3;

  reg  [31:0]             ctrl_ff;
  reg  [1:0]              state_ff;
  reg  [1:0]              nxt_state;
  reg  [`SAW_WAIT_W-1:0]  cnt_ff;
  reg  [`SAW_WAIT_W-1:0]  nxt_cnt;
  reg  [1:0]              hold_ff;
  reg  [1:0]              nxt_hold;
  reg                     mask_ff;
  reg                     nxt_mask;
  reg                     write_ff;
  reg                     nxt_write;
  reg  [ADDR_W-1:0]       addr_ff;
  reg  [ADDR_W-1:0]       nxt_addr;
  reg  [DATA_W-1:0]       wdata_ff;
  reg  [DATA_W-1:0]       nxt_wdata;
  reg  [DATA_W-1:0]       rdata_ff;
  reg  [DATA_W-1:0]       nxt_rdata;
  reg                     done_ff;
  reg                     nxt_done;
  reg                     cs_n_ff;
  reg                     rd_n_ff;
  reg                     we_n_ff;
  reg                     oe_n_ff;
  reg                     stall_ff;
  reg                     nxt_stall;
  wire [`SAW_WAIT_W-1:0]  dec_waits;
  wire                    ext_stall;
  wire                    apb_access;
  wire                    hit_ctrl;
  wire                    hit_stat;

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  // zero wait states; ce low holds pready low so no access is lost
  assign pready     = ce;
  assign hit_ctrl   = (paddr == `SAW_CTRL_OFFSET);
  assign hit_stat   = (paddr == `SAW_STAT_OFFSET);
  assign pslverr    = psel & penable & ~(hit_ctrl | hit_stat);
  assign apb_access = psel & penable & ce;

  always @* begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata = ctrl_ff;
    end else if (hit_stat) begin
      prdata[`SAW_STAT_BUSY]  = (state_ff != ST_IDLE);
      prdata[`SAW_STAT_STALL] = stall_ff;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      ctrl_ff <= `SAW_CTRL_RESET;
    end else if (apb_access && pwrite && hit_ctrl) begin
      ctrl_ff <= pwdata & `SAW_CTRL_WMASK;
    end
  end

  // ----------------------------------------------------------------------
  // wait decode
  // ----------------------------------------------------------------------
  saw_wait_decode u_dec (
    .access_wait         (ctrl_ff[`SAW_AW_MSB:`SAW_AW_LSB]),
    .write_wait_override (ctrl_ff[`SAW_WW_MSB:`SAW_WW_LSB]),
    .is_write            (req_write),
    .wait_cycles         (dec_waits)
  );

  // ----------------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------------
  // settings are latched at request time so a register write cannot
  // reshape an access already on the pins
  assign req_ready = ce & (state_ff == ST_IDLE);
  assign ext_stall = ~mask_ff & ~ext_wait_n;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_hold  = hold_ff;
    nxt_mask  = mask_ff;
    nxt_write = write_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_done  = 1'b0;
    nxt_stall = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (req_valid) begin
          nxt_state = ST_SETUP;
          nxt_cnt   = dec_waits;
          nxt_hold  = ctrl_ff[`SAW_HW_MSB:`SAW_HW_LSB];
          nxt_mask  = ctrl_ff[`SAW_WM_BIT];
          nxt_write = req_write;
          nxt_addr  = req_addr;
          nxt_wdata = req_wdata;
        end
      end
      ST_SETUP: begin
        nxt_state = ST_STROBE;
      end
      ST_STROBE: begin
        if (cnt_ff != 5'h00) begin
          nxt_cnt = cnt_ff - 5'h01;
        end else if (ext_stall) begin
          nxt_stall = 1'b1;
        end else begin
          nxt_state = ST_HOLD;
          nxt_cnt   = {3'h0, hold_ff};
          if (!write_ff) begin
            nxt_rdata = mem_data_in;
          end
        end
      end
      ST_HOLD: begin
        // half cycles round up: code k keeps select for k+1 cycles
        if (cnt_ff == 5'h00) begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 5'h00;
      hold_ff  <= 2'h0;
      mask_ff  <= 1'b1;
      write_ff <= 1'b0;
      addr_ff  <= {ADDR_W{1'b0}};
      wdata_ff <= {DATA_W{1'b0}};
      rdata_ff <= {DATA_W{1'b0}};
      done_ff  <= 1'b0;
      stall_ff <= 1'b0;
      cs_n_ff  <= 1'b1;
      rd_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      hold_ff  <= nxt_hold;
      mask_ff  <= nxt_mask;
      write_ff <= nxt_write;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      done_ff  <= nxt_done;
      stall_ff <= nxt_stall;
      cs_n_ff  <= (nxt_state == ST_IDLE);
      rd_n_ff  <= ~((nxt_state == ST_STROBE) & ~nxt_write);
      we_n_ff  <= ~((nxt_state == ST_STROBE) & nxt_write);
      oe_n_ff  <= ~((nxt_state != ST_IDLE) & nxt_write);
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign req_done      = done_ff;
  assign req_rdata     = rdata_ff;
  assign chip_select_n = cs_n_ff;
  assign mem_addr      = addr_ff;
  assign rd_n          = rd_n_ff;
  assign we_n          = we_n_ff;
  assign mem_data_out  = wdata_ff;
  assign mem_data_oe_n = oe_n_ff;

endmodule // saw_ctrl
`default_nettype wire

// ### sim/saw_assertions.sv
/* checker of strobe, hold and register timing at the saw_ctrl ports.
   assumes control is written only while no access runs. */
`timescale 1ns/1ps
`default_nettype none
`include "saw_regs.vh"
module saw_assertions (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        req_done,
  input wire logic        chip_select_n,
  input wire logic        rd_n,
  input wire logic        we_n,
  input wire logic        mem_data_oe_n,
  input wire logic        ext_wait_n
);
  // ----
  // control shadow and counters
  // ----
  logic [31:0] c_ff;
  logic [5:0]  n_ff;
  logic [5:0]  h_ff;
  wire         stb_n = rd_n & we_n;
  wire         acc = psel & penable & ce & (paddr == `SAW_CTRL_OFFSET);
  function automatic int dw(input logic [3:0] a);
    return a < 7 ? a : a < 11 ? 2 * a - 6 : a == 11 ? 18 : 24;
  endfunction
  function automatic int ww(input logic [31:0] c);
    return c[18:16] != 0 ? c[18:16] - 1 : dw(c[10:7]);
  endfunction
  always @(posedge clock) begin
    if (!rstn) begin
      c_ff <= `SAW_CTRL_RESET;
      n_ff <= 6'h00;
      h_ff <= 6'h00;
    end else if (ce) begin
      // frozen edges leave the design as it was, so they are not counted
      if (acc & pwrite)
        c_ff <= pwdata & `SAW_CTRL_WMASK;
      n_ff <= stb_n ? 6'h00 : n_ff + 6'h01;
      // setup cycle counts too, but the strobe clears it before the hold
      h_ff <= (stb_n & ~chip_select_n) ? h_ff + 6'h01 : 6'h00;
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_rd_end;
    $rose(rd_n) && c_ff[6];
  endsequence
  sequence s_wr_end;
    $rose(we_n) && c_ff[6];
  endsequence
  AST_RD_WAITS: assert property (s_rd_end |-> n_ff == dw(c_ff[10:7]) + 1)
    else $error("read strobe length wrong");
  AST_WR_WAITS: assert property (s_wr_end |-> n_ff == ww(c_ff) + 1)
    else $error("write strobe length wrong");
  AST_STRETCH: assert property (!stb_n && !ext_wait_n && !c_ff[6] |=> !stb_n)
    else $error("open wait did not stretch");
  AST_HOLD: assert property ($rose(chip_select_n) |-> h_ff == c_ff[1:0] + 1)
    else $error("hold length wrong");
  AST_DONE: assert property ($rose(chip_select_n) |-> req_done)
    else $error("done not with select release");
  AST_STB_IN_CS: assert property (!stb_n |-> !chip_select_n)
    else $error("strobe outside select");
  AST_SETUP: assert property ($fell(stb_n) |-> !$past(chip_select_n))
    else $error("strobe without setup");
  AST_RSVD: assert property (acc && !pwrite |-> prdata[5:2] == 4'h0)
    else $error("reserved bits not zero");
  AST_DATA_DRIVE: assert property (!stb_n |-> mem_data_oe_n == we_n)
    else $error("data drive does not follow strobe direction");
  AST_DATA_IDLE: assert property (chip_select_n |-> mem_data_oe_n)
    else $error("data driven outside select");
endmodule // saw_assertions
bind saw_ctrl saw_assertions u_chk (.clock, .rstn, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .req_done, .chip_select_n, .rd_n, .we_n, .mem_data_oe_n, .ext_wait_n);
`default_nettype wire

// ### sim/saw_mem_model.sv
/* behavioural asynchronous memory with a programmable external wait.
   assumes strobes and address come from saw_ctrl on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module saw_mem_model (
  input  wire logic        clock,
  input  wire logic        chip_select_n,
  input  wire logic        rd_n,
  input  wire logic        we_n,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_data_out,
  input  wire logic [3:0]  stretch,
  output logic      [15:0] mem_data_in,
  output logic             ext_wait_n
);
  // ----
  // storage, wait and read path
  // ----
  logic [15:0] mem_ff [0:15];
  logic [3:0]  k_ff;
  wire         on = ~chip_select_n & ~(rd_n & we_n);
  always @(posedge clock) begin
    if (!we_n)
      mem_ff[mem_addr[3:0]] <= mem_data_out;
    k_ff <= on ? k_ff + 4'h1 : 4'h0;
  end
  // wait low for the first stretch strobe cycles of an access
  assign ext_wait_n = ~(on & (k_ff < stretch));
  // a released bus shows the inverse, so a stale sample cannot pass
  assign mem_data_in = (on & ~rd_n) ? mem_ff[mem_addr[3:0]] : ~mem_ff[mem_addr[3:0]];
endmodule // saw_mem_model
`default_nettype wire

// ### sim/saw_ctrl_tb.sv
/* self-checking bench of saw_ctrl: apb set-up, accesses, timing.
   assumes the memory model answers on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module saw_ctrl_tb;
  // ----
  // signals, clock and instances
  // ----
  logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, pready, pslverr, req_ready, req_done;
  logic        chip_select_n, rd_n, we_n, mem_data_oe_n, ext_wait_n, e, ce = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, req_rdata, mem_addr, mem_data_out;
  logic [15:0] mem_data_in;
  logic [3:0]  stretch = 4'h0;
  int          miscompares = 0, n_tests = 0;
  int          wt [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
  always #50 clock = ~clock;
  saw_ctrl dut (.clock, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .req_done,
    .req_rdata, .chip_select_n, .mem_addr, .rd_n, .we_n, .mem_data_out, .mem_data_oe_n,
    .mem_data_in, .ext_wait_n);
  saw_mem_model u_mem (.clock, .chip_select_n, .rd_n, .we_n, .mem_addr, .mem_data_out,
    .stretch, .mem_data_in, .ext_wait_n);
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // counts cycles from the take edge to the done pulse
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] wd, input int x);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= wd;
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    @(negedge clock);
    while (req_done !== 1'b1 && n < 300) begin
      n++;
      @(negedge clock);
    end
    chk("access cycles", n, x);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", d, 32'h0000_0540);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped data", d, 32'h0);
    chk("unmapped error", e, 32'h1);
    apb(1'b1, 12'h000, 32'h0007_07c3);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl readback", d, 32'h0007_07c3);
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, 12'h000, 32'h40 | (i << 7));
      acc(1'b1, 16'h3, 16'h5a00 + i, wt[i] + 3);
      acc(1'b0, 16'h3, 16'h0, wt[i] + 3);
      chk("read data", req_rdata, 16'h5a00 + i);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h000, 32'h640 | (i << 16));
      acc(1'b1, 16'h7, 16'h0, (i == 0 ? 24 : i - 1) + 3);
    end
    acc(1'b0, 16'h7, 16'h0, 27);
    chk("read data", req_rdata, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, 32'h40 | i);
      acc(1'b0, 16'h7, 16'h0, i + 3);
    end
    // ce low over three edges of the hold phase lengthens the access by three
    apb(1'b1, 12'h000, 32'h40);
    fork
      acc(1'b0, 16'h7, 16'h0, 6);
      begin
        repeat (4) @(posedge clock);
        ce <= 1'b0;
        @(negedge clock);
        chk("pready frozen", pready, 32'h0);
        repeat (3) @(posedge clock);
        ce <= 1'b1;
      end
    join
    apb(1'b0, 12'h004, 32'h0);
    chk("status idle", d, 32'h0);
    stretch <= 4'h3;
    apb(1'b1, 12'h000, 32'h40);
    acc(1'b0, 16'h7, 16'h0, 3);
    apb(1'b1, 12'h000, 32'h0);
    acc(1'b0, 16'h7, 16'h0, 6);
    apb(1'b1, 12'h000, 32'h100);
    acc(1'b1, 16'h7, 16'h0, 6);
    print_verdict();
  end
  initial begin
    #(100 * 20000);
    miscompares++;
    print_verdict();
  end
endmodule // saw_ctrl_tb
`default_nettype wire
